// File: rtl/adc_ctl_consts.vh
// Constants for the converter data-path control block.
// Assumes inclusion by bare name from the rtl files.
`ifndef ADC_CTL_CONSTS_VH
`define ADC_CTL_CONSTS_VH

// Register addresses (7-bit SPI address field)
`define REG_DATA_PATH_CTL 7'h06
`define REG_IFACE_CFG 7'h07

// Reset values
`define DATA_PATH_CTL_RST 8'h80
`define IFACE_CFG_RST 8'h00
`define RESP_RST 16'h0000
`define RESP_AFTER_SOFT_RST 16'h0e00

// Data path control fields
`define SW_SYNC_BIT 7
`define ONE_SHOT_BIT 4
`define SOFT_RST_HI 1
`define SOFT_RST_LO 0
`define SOFT_RST_FIRST 2'h3
`define SOFT_RST_SECOND 2'h2

// Interface configuration fields
`define CRC_SEL_HI 3
`define CRC_SEL_LO 2
`define DIV_HI 1
`define DIV_LO 0
`define CRC_SEL_4 2'h1
`define CRC_SEL_16 2'h2
`define DIV_BY_8 2'h0
`define DIV_BY_4 2'h1
`define DIV_NONE 2'h2

// Divider half periods in system clocks
`define HALF_DIV_8 3'h4
`define HALF_DIV_4 3'h2
`define HALF_DIV_NONE 3'h1

// CRC: x^8 + x^2 + x + 1
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00

// SPI frame and output word geometry
`define SPI_FRAME_BITS 5'h10
`define WORD_LAST_BIT 5'h17
`define LAST_CHANNEL 3'h7
`define CRC4_LAST 2'h3
`define CRC16_LAST 4'hf

// Filter settling time in system clocks
`define SETTLE_CYCLES 12'h400

`endif

// File: rtl/data_clock_gen.v
// Data output clock divider with a shift tick on each falling edge.
// Assumes run_in stays high for a whole output burst.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_consts.vh"

module data_clock_gen (
	input wire clk_sys_in,
	input wire rst_n_in,
	input wire run_in,
	input wire [1:0] div_sel_in,
	output reg data_output_clock_out,
	output reg shift_tick_out
);
	reg [2:0] cnt_ff;
	reg [2:0] half;

	// Code 11 falls back to divide by 4
	always @* begin
		case (div_sel_in)
			`DIV_BY_8: half = `HALF_DIV_8; // R13
			`DIV_NONE: half = `HALF_DIV_NONE; // R13
			default: half = `HALF_DIV_4; // R13
		endcase
	end

	// Tick on the edge where the clock falls: new data then has a whole
	// low phase before the next rise, even with no division
	always @* begin
		shift_tick_out = run_in && data_output_clock_out &&
			(cnt_ff == half - 3'h1); // R13
	end

	// Clock parks low between bursts so the receiver sees clean edges
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_ff <= 3'h0;
			data_output_clock_out <= 1'b0;
		end else if (!run_in) begin
			cnt_ff <= 3'h0;
			data_output_clock_out <= 1'b0;
		end else if (cnt_ff == half - 3'h1) begin
			cnt_ff <= 3'h0;
			data_output_clock_out <= ~data_output_clock_out;
		end else begin
			cnt_ff <= cnt_ff + 3'h1;
		end
	end
endmodule
`default_nettype wire

// File: rtl/adc_data_interface_control.v
// Data path control: SPI registers, sync, soft reset, CRC framing.
// Assumes all inputs synchronous to clk_sys_in; sync_pulse_out is
// wired back to sync_in on the board.
// Overview of operation
// (R1) With one-shot set, each sync rising edge yields exactly one result.
// (R2) Software sync fires when the sync bit goes from zero to one.
// (R3) Soft reset needs a write of 3 then a write of 2 to the reset field.
// (R4) A completed soft reset clears the core and restores every register.
// (R5) The first frame after a soft reset answers with 0x0E00.
// (R6) Soft reset comes purely from SPI writes, no pin involved.
// (R7) With CRC on, a CRC byte replaces the header periodically.
// (R8) The CRC polynomial is x^8 + x^2 + x + 1.
// (R9) CRC runs per channel over conversion data only.
// (R10) Code 00 sends status headers with every result and no CRC.
// (R11) Code 01 replaces the header with CRC every 4 samples.
// (R12) Code 10 replaces the header with CRC every 16 samples.
// (R13) The data clock is the system clock divided by 8, 4 or 2.
// (R14) The host picks no division for decimate 32 on two outputs.
// (R15) Each sync pulse restarts settling and mutes data until it ends.
// (R16) A pending reset after 3 is dropped by any write other than 2.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_consts.vh"

module adc_data_interface_control (
	input wire clk_sys_in,
	input wire rst_n_in,
	input wire spi_sclk_in,
	input wire spi_cs_n_in,
	input wire spi_sdi_in,
	output reg spi_sdo_out,
	input wire sync_in,
	output reg sync_pulse_out,
	input wire sample_valid_in,
	input wire [127:0] sample_data_in,
	input wire [3:0] status_in,
	output wire data_output_clock_out,
	output reg serial_data_outputs_out,
	output reg data_ready_out
);
	localparam ST_IDLE = 1'b0;
	localparam ST_SHIFT = 1'b1;

	reg [7:0] data_path_control_ff;
	reg [7:0] output_interface_config_ff;
	reg rst_armed_ff;
	reg sclk_prev_ff;
	reg cs_prev_ff;
	reg sync_prev_ff;
	reg [4:0] spi_cnt_ff;
	reg [15:0] rx_ff;
	reg [15:0] tx_ff;
	reg [15:0] resp_ff;
	reg [11:0] settle_ff;
	reg one_shot_pend_ff;
	reg state_ff;
	reg [3:0] smp_cnt_ff;
	reg [2:0] ch_ff;
	reg [4:0] bit_ff;
	reg [23:0] sh_ff;
	reg [15:0] data_mem [0:7];
	reg [7:0] hdr_mem [0:7];
	reg [7:0] crc_mem [0:7];
	wire shift_tick;
	integer i;
	reg [7:0] nxt_crc [0:7];
	integer j;
	reg [7:0] rd_val;

	wire [1:0] crc_sel = output_interface_config_ff[`CRC_SEL_HI:`CRC_SEL_LO];
	wire crc_on = (crc_sel == `CRC_SEL_4) || (crc_sel == `CRC_SEL_16);
	wire crc_slot = ((crc_sel == `CRC_SEL_4) &&
		(smp_cnt_ff[1:0] == `CRC4_LAST)) || // R11
		((crc_sel == `CRC_SEL_16) && (smp_cnt_ff == `CRC16_LAST)); // R12
	wire sclk_rise = !spi_cs_n_in && spi_sclk_in && !sclk_prev_ff;
	wire sclk_fall = !spi_cs_n_in && !spi_sclk_in && sclk_prev_ff;
	wire cs_fall = !spi_cs_n_in && cs_prev_ff;
	wire frame_done = spi_cs_n_in && !cs_prev_ff &&
		(spi_cnt_ff == `SPI_FRAME_BITS);
	wire wr_en = frame_done && !rx_ff[15];
	wire [6:0] addr = rx_ff[14:8];
	wire [7:0] wdata = rx_ff[7:0];
	wire wr_ctl = wr_en && (addr == `REG_DATA_PATH_CTL);
	wire wr_cfg = wr_en && (addr == `REG_IFACE_CFG);
	wire soft_rst = wr_ctl && rst_armed_ff &&
		(wdata[`SOFT_RST_HI:`SOFT_RST_LO] == `SOFT_RST_SECOND); // R3 R6
	wire sync_rise = sync_in && !sync_prev_ff;
	wire take = sample_valid_in && (state_ff == ST_IDLE) &&
		(settle_ff == 12'h000) &&
		(!data_path_control_ff[`ONE_SHOT_BIT] || one_shot_pend_ff);
	// Clock starts after the first bit is out and stops on an abort,
	// so no stray edge follows the fall of data_ready_out
	wire data_output_clock_run = (state_ff == ST_SHIFT) && (bit_ff != 5'h00) &&
		!sync_rise && !soft_rst; // R15

	// One CRC step over a 16-bit data word, MSB first
	function [7:0] crc8_word;
		input [7:0] crc;
		input [15:0] data;
		integer k;
		reg [7:0] c;
		begin
			c = crc;
			for (k = 15; k >= 0; k = k - 1) begin
				if (c[7] ^ data[k])
					c = {c[6:0], 1'b0} ^ `CRC_POLY; // R8
				else
					c = {c[6:0], 1'b0};
			end
			crc8_word = c;
		end
	endfunction

	// Register readback value
	always @* begin
		case (addr)
			`REG_DATA_PATH_CTL: rd_val = data_path_control_ff;
			`REG_IFACE_CFG: rd_val = output_interface_config_ff;
			default: rd_val = 8'h00;
		endcase
	end

	// Running CRC of each channel with the incoming word folded in
	always @* begin
		for (j = 0; j < 8; j = j + 1)
			nxt_crc[j] = crc8_word(crc_mem[j],
				sample_data_in[j*16 +: 16]); // R9
	end

	data_clock_gen u_data_output_clock (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.run_in(data_output_clock_run),
		.div_sel_in(output_interface_config_ff[`DIV_HI:`DIV_LO]),
		.data_output_clock_out(data_output_clock_out),
		.shift_tick_out(shift_tick)
	);

	// SPI slave: shift in on rising SCLK, out on falling, act at CS rise
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sclk_prev_ff <= 1'b0;
			cs_prev_ff <= 1'b1;
			spi_cnt_ff <= 5'h00;
			rx_ff <= 16'h0000;
			tx_ff <= 16'h0000;
			spi_sdo_out <= 1'b0;
			resp_ff <= `RESP_RST;
			data_path_control_ff <= `DATA_PATH_CTL_RST;
			output_interface_config_ff <= `IFACE_CFG_RST;
			rst_armed_ff <= 1'b0;
			sync_pulse_out <= 1'b0;
		end else begin
			sclk_prev_ff <= spi_sclk_in;
			cs_prev_ff <= spi_cs_n_in;
			sync_pulse_out <= 1'b0;
			if (cs_fall) begin
				spi_cnt_ff <= 5'h00;
				tx_ff <= resp_ff;
				spi_sdo_out <= resp_ff[15];
			end else if (sclk_rise) begin
				rx_ff <= {rx_ff[14:0], spi_sdi_in};
				if (spi_cnt_ff != `SPI_FRAME_BITS)
					spi_cnt_ff <= spi_cnt_ff + 5'h01;
			end else if (sclk_fall) begin
				tx_ff <= {tx_ff[14:0], 1'b0};
				spi_sdo_out <= tx_ff[14];
			end
			if (soft_rst) begin
				data_path_control_ff <= `DATA_PATH_CTL_RST; // R4
				output_interface_config_ff <= `IFACE_CFG_RST; // R4
				rst_armed_ff <= 1'b0;
				resp_ff <= `RESP_AFTER_SOFT_RST; // R5
			end else if (frame_done) begin
				resp_ff <= {rx_ff[15:8], rd_val};
				// Any other write drops a half-done reset sequence
				if (wr_en)
					rst_armed_ff <= wr_ctl && // R16
						(wdata[`SOFT_RST_HI:`SOFT_RST_LO] ==
						`SOFT_RST_FIRST); // R3
				if (wr_ctl) begin
					data_path_control_ff <= wdata;
					if (wdata[`SW_SYNC_BIT] &&
						!data_path_control_ff[`SW_SYNC_BIT])
						sync_pulse_out <= 1'b1; // R2
				end
				if (wr_cfg)
					output_interface_config_ff <= wdata;
			end
		end
	end

	// Core: settling, one-shot gating, CRC and serial framing
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync_prev_ff <= 1'b0;
			settle_ff <= `SETTLE_CYCLES;
			one_shot_pend_ff <= 1'b0;
			state_ff <= ST_IDLE;
			smp_cnt_ff <= 4'h0;
			ch_ff <= 3'h0;
			bit_ff <= 5'h00;
			sh_ff <= 24'h000000;
			serial_data_outputs_out <= 1'b0;
			data_ready_out <= 1'b0;
			for (i = 0; i < 8; i = i + 1) begin
				data_mem[i] <= 16'h0000;
				hdr_mem[i] <= 8'h00;
				crc_mem[i] <= `CRC_INIT;
			end
		end else if (soft_rst) begin
			sync_prev_ff <= sync_in;
			settle_ff <= `SETTLE_CYCLES; // R4
			one_shot_pend_ff <= 1'b0;
			state_ff <= ST_IDLE;
			smp_cnt_ff <= 4'h0;
			ch_ff <= 3'h0;
			bit_ff <= 5'h00;
			sh_ff <= 24'h000000;
			serial_data_outputs_out <= 1'b0;
			data_ready_out <= 1'b0;
			for (i = 0; i < 8; i = i + 1)
				crc_mem[i] <= `CRC_INIT; // R4
		end else begin
			sync_prev_ff <= sync_in;
			// A sync aborts any burst: filters restart from scratch
			if (sync_rise) begin
				settle_ff <= `SETTLE_CYCLES; // R15
				one_shot_pend_ff <= 1'b1; // R1
				state_ff <= ST_IDLE;
				data_ready_out <= 1'b0;
				serial_data_outputs_out <= 1'b0;
			end else if (settle_ff != 12'h000) begin
				settle_ff <= settle_ff - 12'h001; // R15
			end
			case (state_ff)
				ST_IDLE: begin
					// Samples arriving mid-burst are dropped, no buffer
					if (take && !sync_rise) begin
						one_shot_pend_ff <= 1'b0; // R1
						smp_cnt_ff <= smp_cnt_ff + 4'h1;
						for (i = 0; i < 8; i = i + 1) begin
							data_mem[i] <= sample_data_in[i*16 +: 16];
							if (crc_on && crc_slot) begin
								hdr_mem[i] <= nxt_crc[i]; // R7
								crc_mem[i] <= `CRC_INIT;
							end else begin
								hdr_mem[i] <= {i[2:0], 1'b0, status_in}; // R10
								crc_mem[i] <= crc_on ? nxt_crc[i] : `CRC_INIT;
							end
						end
						state_ff <= ST_SHIFT;
						ch_ff <= 3'h0;
						bit_ff <= 5'h00;
						data_ready_out <= 1'b1;
						sh_ff <= 24'h000000;
						serial_data_outputs_out <= 1'b0;
					end
				end
				ST_SHIFT: begin
					if (!sync_rise && bit_ff == 5'h00 && ch_ff == 3'h0 &&
						sh_ff == 24'h000000 && !shift_tick) begin
						sh_ff <= {hdr_mem[0], data_mem[0]};
						serial_data_outputs_out <= hdr_mem[0][7];
						bit_ff <= 5'h01;
					end else if (!sync_rise && shift_tick) begin
						if (bit_ff == `WORD_LAST_BIT + 5'h01) begin
							if (ch_ff == `LAST_CHANNEL) begin
								state_ff <= ST_IDLE;
								data_ready_out <= 1'b0;
								serial_data_outputs_out <= 1'b0;
								sh_ff <= 24'h000000;
								bit_ff <= 5'h00;
							end else begin
								ch_ff <= ch_ff + 3'h1;
								sh_ff <= {hdr_mem[ch_ff + 3'h1],
									data_mem[ch_ff + 3'h1]};
								serial_data_outputs_out <=
									hdr_mem[ch_ff + 3'h1][7];
								bit_ff <= 5'h01;
							end
						end else begin
							sh_ff <= {sh_ff[22:0], 1'b0};
							serial_data_outputs_out <= sh_ff[22];
							bit_ff <= bit_ff + 5'h01;
						end
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// File: bench/adc_ctl_sva.sv
// Port-level assertions for the data-path control block.
// Assumes sync_in is driven from sync_pulse_out plus the board sync.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_consts.vh"
module adc_ctl_sva (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic spi_sclk_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_sdo_out,
	input wire logic sync_in,
	input wire logic sync_pulse_out,
	input wire logic sample_valid_in,
	input wire logic data_output_clock_out,
	input wire logic data_ready_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);
	logic [7:0] rise_ff;
	logic cut_ff;
	logic [11:0] set_ff;
	// Rises per burst; SPI or sync mid-burst may legally cut it short
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rise_ff <= 8'h00;
			cut_ff <= 1'b0;
		end else if (!data_ready_out) begin
			rise_ff <= 8'h00;
			cut_ff <= 1'b0;
		end else begin
			rise_ff <= rise_ff + {7'h00, $rose(data_output_clock_out)};
			cut_ff <= cut_ff | sync_in | !spi_cs_n_in;
		end
	end
	// Lower bound of the settling wait; late sync sampling only lengthens it
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in)
			set_ff <= `SETTLE_CYCLES;
		else if ($rose(sync_in))
			set_ff <= `SETTLE_CYCLES;
		else if (set_ff != 12'h000)
			set_ff <= set_ff - 12'h001;
	end
	sequence s_go;
		!data_ready_out ##1 data_ready_out;
	endsequence
	sequence s_sync;
		!sync_in ##1 sync_in;
	endsequence
	chk_ready_cause: assert property (s_go |-> $past(sample_valid_in))
		else $error("burst began without a sample");
	chk_ready_settled: assert property (s_go |-> set_ff == 12'h000)
		else $error("burst began while settling");
	chk_sync_abort: assert property (s_sync |-> ##[1:3] !data_ready_out)
		else $error("sync left the burst running");
	chk_burst_bits: assert property ($fell(data_ready_out) && !cut_ff
		|-> rise_ff == 8'hc0)
		else $error("burst length not 192 bits");
	chk_data_output_clock_burst: assert property (data_output_clock_out |-> data_ready_out)
		else $error("data clock ran outside a burst");
	chk_sync_single: assert property (sync_pulse_out |=> !sync_pulse_out)
		else $error("sync pulse longer than a cycle");
	chk_sync_spi: assert property (sync_pulse_out |-> $past(spi_cs_n_in))
		else $error("sync pulse inside a frame");
	chk_sdo_fall: assert property ($changed(spi_sdo_out) && !spi_cs_n_in
		|-> !$past(spi_sclk_in) || $fell(spi_cs_n_in))
		else $error("serial answer moved on a high clock");
endmodule
bind adc_data_interface_control adc_ctl_sva u_sva (
	.clk_sys_in(clk_sys_in),
	.rst_n_in(rst_n_in),
	.spi_sclk_in(spi_sclk_in),
	.spi_cs_n_in(spi_cs_n_in),
	.spi_sdo_out(spi_sdo_out),
	.sync_in(sync_in),
	.sync_pulse_out(sync_pulse_out),
	.sample_valid_in(sample_valid_in),
	.data_output_clock_out(data_output_clock_out),
	.data_ready_out(data_ready_out)
);
`default_nettype wire

// File: bench/adc_host_model.sv
// Host model: SPI frames out, serial data burst captured back.
// Assumes SPI clock levels of at least two system clocks are accepted.
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
	input wire logic clk_in,
	input wire logic sdo_in,
	input wire logic data_output_clock_in,
	input wire logic dout_in,
	output var logic sclk_out,
	output var logic cs_n_out,
	output var logic sdi_out
);
	logic [191:0] bits = '0;
	int cnt = 0;
	int last = 0;
	int per = 0;
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		sdi_out = 1'b0;
	end
	// Idle data line flips so a stale bit is never read as valid
	always @(posedge clk_in) begin
		cnt <= cnt + 1;
		if (cs_n_out)
			sdi_out <= ~sdi_out;
	end
	// Capture on data clock rise; bits move only after its fall
	always @(posedge data_output_clock_in) begin
		bits <= {bits[190:0], dout_in};
		per <= cnt - last;
		last <= cnt;
	end
	// One 16-bit frame, MSB first, answer bit read before each rise
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		@(posedge clk_in);
		#2 cs_n_out = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			repeat (2) @(posedge clk_in);
			#2 sdi_out = w[i];
			repeat (2) @(posedge clk_in);
			#2 r[i] = sdo_in;
			sclk_out = 1'b1;
			repeat (3) @(posedge clk_in);
			#2 sclk_out = 1'b0;
		end
		repeat (3) @(posedge clk_in);
		#2 cs_n_out = 1'b1;
		repeat (3) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the data-path control block.
// Assumes the host model supplies SPI frames and captures bursts.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_sys_in, rst_n_in, tb_sync, sample_valid_in, pulsed;
	logic [127:0] sample_data_in;
	logic [3:0] status_in;
	logic [15:0] rsp;
	logic [7:0] crc [8] = '{default: 8'h00};
	wire sclk, cs_n, sdi, sdo, pulse, data_output_clock, dout, ready, sync_w;
	integer seed = 32'hed84;
	int errors = 0, total_checks = 0, nsmp = 0;
	assign sync_w = tb_sync | pulse;
	initial begin
		clk_sys_in = 1'b0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	adc_data_interface_control u_adc_data_interface_control (
		.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .spi_sclk_in(sclk),
		.spi_cs_n_in(cs_n), .spi_sdi_in(sdi), .spi_sdo_out(sdo),
		.sync_in(sync_w), .sync_pulse_out(pulse),
		.sample_valid_in(sample_valid_in), .sample_data_in(sample_data_in),
		.status_in(status_in), .data_output_clock_out(data_output_clock),
		.serial_data_outputs_out(dout), .data_ready_out(ready));
	adc_host_model u_adc_host_model (.clk_in(clk_sys_in), .sdo_in(sdo),
		.data_output_clock_in(data_output_clock), .dout_in(dout), .sclk_out(sclk), .cs_n_out(cs_n),
		.sdi_out(sdi));
	always @(posedge clk_sys_in) if (pulse === 1'b1) pulsed <= 1'b1;
	task stop_test();
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [191:0] got, input logic [191:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task cmd(input logic [15:0] w);
		u_adc_host_model.xfer(w, rsp);
	endtask
	// Bounded wait for the ready level; a hang ends the run
	task wait_lvl(input logic lvl);
		int n;
		n = 0;
		while (ready !== lvl && n < 4000) begin
			@(posedge clk_sys_in);
			n++;
		end
		if (n >= 4000) begin
			errors++;
			stop_test();
		end
	endtask
	task pulse_valid();
		@(posedge clk_sys_in);
		#2 sample_data_in = {$random(seed), $random(seed), $random(seed),
			$random(seed)};
		status_in = 4'($random(seed));
		sample_valid_in = 1'b1;
		@(posedge clk_sys_in);
		#2 sample_valid_in = 1'b0;
	endtask
	task sync_edge();
		@(posedge clk_sys_in);
		#2 tb_sync = 1'b1;
		repeat (2) @(posedge clk_sys_in);
		#2 tb_sync = 1'b0;
	endtask
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [15:0] d);
		for (int k = 15; k >= 0; k--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[k]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	// One sample through; headers per CRC code, CRC restarts when sent
	task burst(input logic [1:0] sel);
		logic [191:0] e;
		logic [7:0] h;
		pulse_valid();
		nsmp++;
		for (int c = 0; c < 8; c++) begin
			crc[c] = crc8(crc[c], sample_data_in[16*c +: 16]);
			h = {3'(c), 1'b0, status_in};
			if ((sel == 2'h1 && nsmp % 4 == 0) || (sel == 2'h2 && nsmp % 16 == 0)) begin
				h = crc[c];
				crc[c] = 8'h00;
			end
			e = {e[167:0], h, sample_data_in[16*c +: 16]};
		end
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		chk(u_adc_host_model.bits, e);
	endtask
	initial begin
		rst_n_in = 1'b0;
		tb_sync = 1'b0;
		sample_valid_in = 1'b0;
		sample_data_in = '0;
		status_in = 4'h0;
		pulsed = 1'b0;
		repeat (12) @(posedge clk_sys_in);
		#2 rst_n_in = 1'b1;
		repeat (1100) @(posedge clk_sys_in);
		cmd(16'h0705);
		// CRC every 4th, then every 16th at half the system clock, then status only
		for (int i = 0; i < 18; i++) begin
			if (i == 4) cmd(16'h070a);
			if (i == 16) cmd(16'h0700);
			burst(i < 4 ? 2'h1 : (i < 16 ? 2'h2 : 2'h0));
			if (i == 3 || i == 15 || i == 17)
				chk(u_adc_host_model.per, i == 3 ? 4 : (i == 15 ? 2 : 8));
		end
		cmd(16'h0610);
		pulse_valid();
		repeat (50) @(posedge clk_sys_in);
		chk(ready, 1'b0);
		cmd(16'h0690);
		chk(pulsed, 1'b1);
		// A sample during settling must be dropped even with a sync pending
		pulse_valid();
		repeat (50) @(posedge clk_sys_in);
		chk(ready, 1'b0);
		repeat (1100) @(posedge clk_sys_in);
		burst(2'h0);
		pulse_valid();
		repeat (50) @(posedge clk_sys_in);
		chk(ready, 1'b0);
		sync_edge();
		repeat (1100) @(posedge clk_sys_in);
		pulse_valid();
		wait_lvl(1'b1);
		sync_edge();
		repeat (2) @(posedge clk_sys_in);
		chk(ready, 1'b0);
		// Armed reset dropped by another write; codes 1 and 2 alone inert
		cmd(16'h0683);
		cmd(16'h0705);
		cmd(16'h0681);
		cmd(16'h0682);
		cmd(16'h8700);
		cmd(16'h8700);
		chk(rsp, 16'h8705);
		cmd(16'h0683);
		cmd(16'h0682);
		cmd(16'h8600);
		chk(rsp, 16'h0e00);
		cmd(16'ha000);
		chk(rsp, 16'h8680);
		cmd(16'h8700);
		chk(rsp, 16'ha000);
		cmd(16'h8600);
		chk(rsp, 16'h8700);
		stop_test();
	end
endmodule
`default_nettype wire
